// ===== spal_core.sv
// four-channel setpoint and alarm comparator with setpoint view/edit
// assumes readings, buttons and resets arrive synchronous to clk as
// one-cycle pulses, except the external alarm reset which is a level
`timescale 1ns/1ps

module spal_core #(
	parameter int unsigned VIEW_CYCLES = spal_pkg::VIEW_CYCLES
) (
	input  wire logic                              clk,
	input  wire logic                              reset_n,
	input  wire logic                              reading_strobe,
	input  wire logic signed [spal_pkg::VAL_W-1:0] raw_value,
	input  wire logic signed [spal_pkg::VAL_W-1:0] filt_value,
	input  wire logic                              cfg_wr,
	input  wire logic [3:0]                        cfg_sel,
	input  wire logic [spal_pkg::VAL_W-1:0]        cfg_wdata,
	input  wire logic [3:0]                        rd_sel,
	output logic [spal_pkg::VAL_W-1:0]             rd_data,
	input  wire logic                              view_btn,
	input  wire logic                              digit_sel_btn,
	input  wire logic                              digit_inc_btn,
	input  wire logic                              reset_btn,
	input  wire logic                              serial_alarm_reset,
	input  wire logic                              ext_alarm_reset_n,
	output logic [3:0]                             xistor_on,
	output logic [3:0]                             led_on,
	output logic                                   display_flash,
	output logic                                   view_active,
	output logic [1:0]                             view_index,
	output logic signed [spal_pkg::VAL_W-1:0]      view_value,
	output logic [2:0]                             view_digit
);

	localparam int VW = spal_pkg::VAL_W;
	localparam int EW = spal_pkg::EXT_W;
	localparam int DW = spal_pkg::DLY_W;
	localparam int ST = spal_pkg::FLD_STRIDE;

	// configuration storage
	logic [7:0]              sp_cfg_reg;
	logic [7:0]              al_cfg_reg;
	logic [7:0]              alarm_function_select_reg;
	logic [7:0]              out_cfg_reg;
	logic [DW-1:0]           dly_reg [2];
	logic [VW-1:0]           sp_hyst_reg;
	logic [VW-1:0]           al_hyst_reg;
	logic signed [VW-1:0]    lvl_reg [4];

	// view state
	spal_pkg::spal_view_e    view_reg;
	logic [30:0]             tmr_reg;
	logic [1:0]              idx_reg;
	logic [2:0]              pos_reg;
	logic signed [VW-1:0]    edit_reg;
	logic                    dirty_reg;
	logic                    commit;
	logic                    view_done;

	// per-channel activity
	logic [3:0]              act_vec;
	logic [3:0]              pol_vec;
	logic [3:0]              led_en;
	logic                    sp_dis;
	logic                    al_dis;
	logic                    latch_clr;

	function automatic logic signed [EW-1:0] sx(
		input logic signed [VW-1:0] v);
		return {{(EW-VW){v[VW-1]}}, v};
	endfunction

	function automatic logic signed [EW-1:0] ux(input logic [VW-1:0] v);
		return {{(EW-VW){1'b0}}, v};
	endfunction

	assign sp_dis = sp_cfg_reg[spal_pkg::BIT_DIS];
	assign al_dis = al_cfg_reg[spal_pkg::BIT_DIS];
	// latch reset sources; the external pin counts only when gated on
	assign latch_clr = reset_btn | serial_alarm_reset
		| (!ext_alarm_reset_n & al_cfg_reg[spal_pkg::BIT_EXTGT]);

	// configuration bytes, delays and hysteresis
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sp_cfg_reg  <= spal_pkg::CFG_RST;
			al_cfg_reg  <= spal_pkg::CFG_RST;
			alarm_function_select_reg  <= spal_pkg::CFG_RST;
			out_cfg_reg <= spal_pkg::CFG_RST;
			dly_reg[0]  <= spal_pkg::DLY_RST;
			dly_reg[1]  <= spal_pkg::DLY_RST;
			sp_hyst_reg <= spal_pkg::VAL_RST;
			al_hyst_reg <= spal_pkg::VAL_RST;
		end else if (cfg_wr) begin
			case (cfg_sel)
				spal_pkg::SEL_SP_CFG:  sp_cfg_reg  <= cfg_wdata[7:0];
				spal_pkg::SEL_AL_CFG:  al_cfg_reg  <= cfg_wdata[7:0];
				spal_pkg::SEL_ALARM_FUNCTION_SELECT:  alarm_function_select_reg  <= cfg_wdata[7:0];
				spal_pkg::SEL_OUT_CFG: out_cfg_reg <= cfg_wdata[7:0];
				spal_pkg::SEL_DLY3:    dly_reg[0]  <= cfg_wdata[DW-1:0];
				spal_pkg::SEL_DLY4:    dly_reg[1]  <= cfg_wdata[DW-1:0];
				spal_pkg::SEL_SP_HYST: sp_hyst_reg <= cfg_wdata;
				spal_pkg::SEL_AL_HYST: al_hyst_reg <= cfg_wdata;
				default: ;
			endcase
		end
	end

	// levels: direct write or commit from the view editor
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int i = 0; i < 4; i++) begin
				lvl_reg[i] <= spal_pkg::VAL_RST;
			end
		end else if (commit) begin
			lvl_reg[idx_reg] <= edit_reg;
		end else if (cfg_wr && cfg_sel[3:2] == spal_pkg::SEL_LEVEL1[3:2])
		begin
			lvl_reg[cfg_sel[1:0]] <= cfg_wdata;
		end
	end

	// view cycle: step, timeout, edit, commit or discard
	assign view_done = (tmr_reg == 31'(VIEW_CYCLES - 1));
	// reset outranks the view button, so a joint press never stores
	assign commit = (view_reg == spal_pkg::SPAL_VIEW_SHOW) && view_btn
		&& dirty_reg && !reset_btn;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			view_reg  <= spal_pkg::SPAL_VIEW_IDLE;
			tmr_reg   <= 31'h00000000;
			idx_reg   <= 2'h0;
			pos_reg   <= 3'h0;
			edit_reg  <= spal_pkg::VAL_RST;
			dirty_reg <= 1'b0;
		end else begin
			case (view_reg)
				spal_pkg::SPAL_VIEW_IDLE: begin
					if (view_btn) begin
						view_reg  <= spal_pkg::SPAL_VIEW_SHOW;
						idx_reg   <= 2'h0;
						edit_reg  <= lvl_reg[0];
						tmr_reg   <= 31'h00000000;
						pos_reg   <= 3'h0;
						dirty_reg <= 1'b0;
					end
				end
				spal_pkg::SPAL_VIEW_SHOW: begin
					if (reset_btn) begin
						view_reg <= spal_pkg::SPAL_VIEW_IDLE;
					end else if (view_btn) begin
						dirty_reg <= 1'b0;
						tmr_reg   <= 31'h00000000;
						pos_reg   <= 3'h0;
						if (idx_reg == 2'h3) begin
							view_reg <= spal_pkg::SPAL_VIEW_IDLE;
						end else begin
							idx_reg  <= idx_reg + 2'h1;
							edit_reg <= lvl_reg[idx_reg + 2'h1];
						end
					end else if (digit_sel_btn) begin
						tmr_reg <= 31'h00000000;
						pos_reg <= (pos_reg == 3'(spal_pkg::N_DIGITS - 1))
							? 3'h0 : pos_reg + 3'h1;
					end else if (digit_inc_btn) begin
						tmr_reg   <= 31'h00000000;
						edit_reg  <= edit_reg
							+ $signed(spal_pkg::DIGIT_WEIGHT[pos_reg]);
						dirty_reg <= 1'b1;
					end else if (view_done) begin
						tmr_reg   <= 31'h00000000;
						pos_reg   <= 3'h0;
						dirty_reg <= 1'b0;
						if (idx_reg == 2'h3) begin
							view_reg <= spal_pkg::SPAL_VIEW_IDLE;
						end else begin
							idx_reg  <= idx_reg + 2'h1;
							edit_reg <= lvl_reg[idx_reg + 2'h1];
						end
					end else begin
						tmr_reg <= tmr_reg + 31'h00000001;
					end
				end
				default: view_reg <= spal_pkg::SPAL_VIEW_IDLE;
			endcase
		end
	end

	// one comparator and delay counter per channel; only the two alarm channels latch
	for (genvar g = 0; g < 4; g++) begin : ch
		localparam int  P  = g % 2;
		localparam bit  AL = (g >= 2);
		logic [7:0]           cfg;
		logic                 dir, filt, latch, dis;
		logic [1:0]           place;
		logic [DW-1:0]        dly;
		logic signed [EW-1:0] m, own, part, hh, ah, lv, up, lo;
		logic                 on_c, off_c;
		logic                 act_reg;
		logic [DW-1:0]        cnt_reg;
		logic [DW:0]          cnt_inc;

		assign cfg   = AL ? al_cfg_reg : sp_cfg_reg;
		assign dir   = cfg[P*ST + spal_pkg::BIT_DIR];
		assign filt  = cfg[P*ST + spal_pkg::BIT_FILT];
		assign place = alarm_function_select_reg[P*ST + spal_pkg::BIT_PLACE +: 2];
		// only the alarms may latch or delay
		assign latch = AL & alarm_function_select_reg[P*ST + spal_pkg::BIT_LATCH];
		assign dly   = AL ? dly_reg[P] : spal_pkg::DLY_RST;
		assign dis   = AL ? al_dis : sp_dis;
		assign cnt_inc = {1'b0, cnt_reg} + {{DW{1'b0}}, 1'b1};
		assign act_vec[g] = act_reg;
		assign pol_vec[g] = cfg[P*ST + spal_pkg::BIT_POL];
		assign led_en[g]  = AL ? !al_dis
			: !sp_dis && !sp_cfg_reg[spal_pkg::BIT_LEDDIS];

		// activation and release conditions for this channel
		always_comb begin
			m     = filt ? sx(filt_value) : sx(raw_value);
			own   = sx(lvl_reg[g]);
			part  = sx(lvl_reg[P]);
			hh    = ux(sp_hyst_reg) >>> 1;
			ah    = ux(al_hyst_reg);
			up    = part + own;
			lo    = part - own;
			lv    = own;
			on_c  = 1'b0;
			off_c = 1'b0;
			if (!AL) begin
				// split hysteresis around the level
				on_c  = dir ? (m < own - hh) : (m > own + hh);
				off_c = dir ? (m > own + hh) : (m < own - hh);
			end else if (place == spal_pkg::PLACE_BAND) begin
				if (!dir) begin
					on_c  = (m > up) || (m < lo);
					off_c = (m < up - ah) && (m > lo + ah);
				end else begin
					on_c  = (m < up) && (m > lo);
					off_c = (m > up + ah) || (m < lo - ah);
				end
			end else begin
				case (place)
					spal_pkg::PLACE_ABOVE: lv = up;
					spal_pkg::PLACE_BELOW: lv = lo;
					default:               lv = own;
				endcase
				// hysteresis only on the inactive side
				on_c  = dir ? (m < lv) : (m > lv);
				off_c = dir ? (m > lv + ah) : (m < lv - ah);
			end
		end

		// activity, delay count and latch; a set beats a latch reset
		always_ff @(posedge clk) begin
			if (!reset_n) begin
				act_reg <= 1'b0;
				cnt_reg <= spal_pkg::DLY_RST;
			end else if (dis) begin
				act_reg <= 1'b0;
				cnt_reg <= spal_pkg::DLY_RST;
			end else begin
				if (latch_clr && AL) begin
					act_reg <= 1'b0;
				end
				if (reading_strobe) begin
					if (on_c) begin
						if (cnt_reg < dly) begin
							cnt_reg <= cnt_inc[DW-1:0];
						end
						if (cnt_inc >= {1'b0, dly}) begin
							act_reg <= 1'b1;
						end
					end else begin
						cnt_reg <= spal_pkg::DLY_RST;
						if (off_c && !(latch && act_reg)) begin
							act_reg <= 1'b0;
						end
					end
				end
			end
		end
	end

	// registered pin outputs
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			xistor_on <= 4'h0;
			led_on    <= 4'h0;
		end else begin
			xistor_on <= act_vec ^ pol_vec;
			led_on    <= act_vec & led_en;
		end
	end

	// display flash selector
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			display_flash <= 1'b0;
		end else begin
			case (out_cfg_reg[spal_pkg::BIT_FLASH +: 3])
				3'h1:                display_flash <= act_vec[0];
				3'h2:                display_flash <= act_vec[1];
				3'h3:                display_flash <= act_vec[2];
				3'h4:                display_flash <= act_vec[3];
				spal_pkg::FLASH_ANY: display_flash <= |act_vec;
				default:             display_flash <= 1'b0;
			endcase
		end
	end

	// view outputs and configuration readback
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			view_active <= 1'b0;
			view_index  <= 2'h0;
			view_value  <= spal_pkg::VAL_RST;
			view_digit  <= 3'h0;
			rd_data     <= spal_pkg::VAL_RST;
		end else begin
			view_active <= (view_reg == spal_pkg::SPAL_VIEW_SHOW);
			view_index  <= idx_reg;
			view_value  <= edit_reg;
			view_digit  <= pos_reg;
			case (rd_sel)
				spal_pkg::SEL_SP_CFG:  rd_data <= VW'(sp_cfg_reg);
				spal_pkg::SEL_AL_CFG:  rd_data <= VW'(al_cfg_reg);
				spal_pkg::SEL_ALARM_FUNCTION_SELECT:  rd_data <= VW'(alarm_function_select_reg);
				spal_pkg::SEL_OUT_CFG: rd_data <= VW'(out_cfg_reg);
				spal_pkg::SEL_DLY3:    rd_data <= VW'(dly_reg[0]);
				spal_pkg::SEL_DLY4:    rd_data <= VW'(dly_reg[1]);
				spal_pkg::SEL_SP_HYST: rd_data <= sp_hyst_reg;
				spal_pkg::SEL_AL_HYST: rd_data <= al_hyst_reg;
				spal_pkg::SEL_STATUS:  rd_data <= VW'(act_vec);
				4'h8, 4'h9, 4'ha, 4'hb: rd_data <= lvl_reg[rd_sel[1:0]];
				default:               rd_data <= spal_pkg::VAL_RST;
			endcase
		end
	end

	// checks
	property p_sp_disable;
		@(posedge clk) disable iff (!reset_n)
		sp_dis |=> act_vec[1:0] == 2'h0
			##1 xistor_on[1:0] == $past(pol_vec[1:0]);
	endproperty
	a_sp_disable: assert property (p_sp_disable)
		else $error("setpoint pair active while disabled");

	property p_al_disable;
		@(posedge clk) disable iff (!reset_n)
		al_dis |=> act_vec[3:2] == 2'h0 ##1 led_on[3:2] == 2'h0;
	endproperty
	a_al_disable: assert property (p_al_disable)
		else $error("alarm pair active while disabled");

	property p_polarity;
		@(posedge clk) disable iff (!reset_n)
		##1 xistor_on == ($past(act_vec) ^ $past(pol_vec));
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("transistor sense does not follow polarity");

	property p_led_dark;
		@(posedge clk) disable iff (!reset_n)
		sp_cfg_reg[spal_pkg::BIT_LEDDIS] |=> led_on[1:0] == 2'h0;
	endproperty
	a_led_dark: assert property (p_led_dark)
		else $error("setpoint LED lit while darkened");

	property p_strobe_only;
		@(posedge clk) disable iff (!reset_n)
		!reading_strobe && !latch_clr && !sp_dis && !al_dis
			|=> act_vec == $past(act_vec);
	endproperty
	a_strobe_only: assert property (p_strobe_only)
		else $error("activity changed without a reading");

	property p_ext_ignored;
		@(posedge clk) disable iff (!reset_n)
		!al_cfg_reg[spal_pkg::BIT_EXTGT] && !ext_alarm_reset_n
			&& !reset_btn && !serial_alarm_reset && !reading_strobe
			&& !al_dis && act_vec[2] |=> act_vec[2];
	endproperty
	a_ext_ignored: assert property (p_ext_ignored)
		else $error("ungated external reset cleared an alarm");

	property p_latch_hold;
		@(posedge clk) disable iff (!reset_n)
		alarm_function_select_reg[spal_pkg::BIT_LATCH] && act_vec[2] && !latch_clr
			&& !al_dis |=> act_vec[2];
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("latched alarm released without reset");

	property p_sp_no_latch_clear;
		@(posedge clk) disable iff (!reset_n)
		latch_clr && !reading_strobe && !sp_dis
			|=> act_vec[1:0] == $past(act_vec[1:0]);
	endproperty
	a_sp_no_latch_clear: assert property (p_sp_no_latch_clear)
		else $error("latch reset touched a setpoint");

	property p_flash_off;
		@(posedge clk) disable iff (!reset_n)
		out_cfg_reg[spal_pkg::BIT_FLASH +: 3] == 3'h0 |=> !display_flash;
	endproperty
	a_flash_off: assert property (p_flash_off)
		else $error("display flashing while disabled");

	property p_commit;
		@(posedge clk) disable iff (!reset_n)
		commit |=> lvl_reg[$past(idx_reg)] == $past(edit_reg);
	endproperty
	a_commit: assert property (p_commit)
		else $error("edited level not stored on view press");

	property p_discard;
		@(posedge clk) disable iff (!reset_n)
		view_reg == spal_pkg::SPAL_VIEW_SHOW && reset_btn && !cfg_wr
			|=> $stable(lvl_reg[0]) && $stable(lvl_reg[1])
			&& view_reg == spal_pkg::SPAL_VIEW_IDLE;
	endproperty
	a_discard: assert property (p_discard)
		else $error("reset did not discard the edit");

	property p_cv_latched;
		@(posedge clk) disable iff (!reset_n)
		act_vec[2] && alarm_function_select_reg[spal_pkg::BIT_LATCH] ##1 latch_clr;
	endproperty
	c_cv_latched: cover property (p_cv_latched);

	property p_cv_commit;
		@(posedge clk) disable iff (!reset_n)
		commit;
	endproperty
	c_cv_commit: cover property (p_cv_commit);

	property p_cv_band;
		@(posedge clk) disable iff (!reset_n)
		alarm_function_select_reg[1:0] == spal_pkg::PLACE_BAND && $rose(act_vec[2]);
	endproperty
	c_cv_band: cover property (p_cv_band);

endmodule

// ===== spal_pkg.sv
// constants, field layout and reset values for the setpoint/alarm logic
// assumes a 100 MHz clock; shared by the core and its testbench
package spal_pkg;

	// measurement and level width, and the widened width used for sums
	localparam int VAL_W = 20;
	localparam int EXT_W = 22;
	localparam int DLY_W = 7;

	// configuration write/read selectors
	localparam logic [3:0] SEL_SP_CFG  = 4'h0;
	localparam logic [3:0] SEL_AL_CFG  = 4'h1;
	localparam logic [3:0] SEL_ALARM_FUNCTION_SELECT  = 4'h2;
	localparam logic [3:0] SEL_DLY3    = 4'h3;
	localparam logic [3:0] SEL_DLY4    = 4'h4;
	localparam logic [3:0] SEL_SP_HYST = 4'h5;
	localparam logic [3:0] SEL_AL_HYST = 4'h6;
	localparam logic [3:0] SEL_OUT_CFG = 4'h7;
	localparam logic [3:0] SEL_LEVEL1  = 4'h8; // levels at 8..b
	localparam logic [3:0] SEL_STATUS  = 4'hc;

	// per-pair bit positions; the second member sits FLD_STRIDE higher
	localparam int FLD_STRIDE = 3;
	localparam int BIT_DIR    = 0;
	localparam int BIT_POL    = 1;
	localparam int BIT_FILT   = 2;
	localparam int BIT_DIS    = 6;
	localparam int BIT_LEDDIS = 7; // in setpoint_pair_config
	localparam int BIT_EXTGT  = 7; // in alarm_pair_config
	localparam int BIT_PLACE  = 0; // two bits in alarm_function_select
	localparam int BIT_LATCH  = 2;
	localparam int BIT_FLASH  = 5; // three bits in output_config_byte

	// placement codes of an alarm against its partner setpoint
	localparam logic [1:0] PLACE_INDEP = 2'h0;
	localparam logic [1:0] PLACE_ABOVE = 2'h1;
	localparam logic [1:0] PLACE_BELOW = 2'h2;
	localparam logic [1:0] PLACE_BAND  = 2'h3;

	// flash selector code for "any setpoint active"
	localparam logic [2:0] FLASH_ANY = 3'h5;

	// reset values
	localparam logic [7:0]       CFG_RST  = 8'h00;
	localparam logic [DLY_W-1:0] DLY_RST  = 7'h00;
	localparam logic [VAL_W-1:0] VAL_RST  = 20'h00000;

	// setpoint view interval
	localparam int CLK_HZ          = 100_000_000;
	localparam int VIEW_INTERVAL_S = 15;
	localparam int VIEW_CYCLES     = VIEW_INTERVAL_S * CLK_HZ;

	// digit weights for the edit cursor, least significant first
	localparam int N_DIGITS = 5;
	localparam logic [VAL_W-1:0] DIGIT_WEIGHT [N_DIGITS] = '{
		20'h00001, 20'h0000a, 20'h00064, 20'h003e8, 20'h02710};

	typedef enum logic {SPAL_VIEW_IDLE, SPAL_VIEW_SHOW} spal_view_e;

endpackage

// ===== spal_front_model.sv
// measurement front end model: one reading per call, strobed one cycle
// assumes calls start just after a falling edge of the core clock
`timescale 1ns/1ps

module spal_front_model (
	input  wire logic                         clk,
	output logic                              reading_strobe,
	output logic signed [spal_pkg::VAL_W-1:0] raw_value,
	output logic signed [spal_pkg::VAL_W-1:0] filt_value
);
	// no reading is presented before the first call
	initial begin
		reading_strobe = 1'b0;
		raw_value = '0;
		filt_value = '0;
	end

	// values are scrambled once the strobe drops, so none lingers
	task automatic read(input logic [spal_pkg::VAL_W-1:0] r,
		input logic [spal_pkg::VAL_W-1:0] f);
		@(negedge clk);
		reading_strobe = 1'b1;
		raw_value = r;
		filt_value = f;
		@(negedge clk);
		reading_strobe = 1'b0;
		raw_value = ~r;
		filt_value = ~f;
	endtask
endmodule

// ===== spal_core_tb.sv
// self-checking bench for the setpoint and alarm core
// assumes the package and the front end model are compiled before it
`timescale 1ns/1ps

module spal_core_tb;
	logic                             clk;
	logic                             reset_n;
	logic                             cfg_wr;
	logic [3:0]                       cfg_sel;
	logic [spal_pkg::VAL_W-1:0]       cfg_wdata;
	logic [3:0]                       rd_sel;
	logic [spal_pkg::VAL_W-1:0]       rd_data;
	logic                             view_btn;
	logic                             digit_sel_btn;
	logic                             serial_alarm_reset;
	logic                             digit_inc_btn;
	logic                             reset_btn;
	logic                             ext_alarm_reset_n;
	logic                             strobe;
	logic signed [spal_pkg::VAL_W-1:0] raw;
	logic signed [spal_pkg::VAL_W-1:0] filt;
	logic [3:0]                       xistor_on;
	logic [3:0]                       led_on;
	logic                             display_flash;
	logic                             view_active;
	logic [1:0]                       view_index;
	logic signed [spal_pkg::VAL_W-1:0] view_value;
	logic [2:0]                       view_digit;
	int                               n_fail;
	int                               n_compared;
	int                               cyc;

	// core with a short view interval
	spal_core #(.VIEW_CYCLES(50)) u_dut (
		.clk(clk), .reset_n(reset_n), .reading_strobe(strobe),
		.raw_value(raw), .filt_value(filt), .cfg_wr(cfg_wr),
		.cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata), .rd_sel(rd_sel),
		.rd_data(rd_data), .view_btn(view_btn),
		.digit_sel_btn(digit_sel_btn),
		.digit_inc_btn(digit_inc_btn), .reset_btn(reset_btn),
		.serial_alarm_reset(serial_alarm_reset),
		.ext_alarm_reset_n(ext_alarm_reset_n),
		.xistor_on(xistor_on), .led_on(led_on),
		.display_flash(display_flash), .view_active(view_active),
		.view_index(view_index), .view_value(view_value),
		.view_digit(view_digit)
	);

	// measurement front end
	spal_front_model u_fe (
		.clk(clk), .reading_strobe(strobe), .raw_value(raw),
		.filt_value(filt)
	);

	// 100 MHz clock
	always #5 clk = ~clk;

	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			test_done();
		end
	end

	task automatic test_done();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic gap(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic wr(input logic [3:0] s, input logic [19:0] d);
		@(negedge clk);
		cfg_wr = 1'b1;
		cfg_sel = s;
		cfg_wdata = d;
		@(negedge clk);
		cfg_wr = 1'b0;
	endtask

	task automatic rd(input logic [3:0] s, input logic [19:0] e);
		@(negedge clk);
		rd_sel = s;
		@(negedge clk);
		chk(rd_data, e);
	endtask

	// one reading, then wait until the outputs have settled
	task automatic rdg(input logic [19:0] r, input logic [19:0] f);
		u_fe.read(r, f);
		gap(2);
	endtask

	task automatic out(input logic [3:0] x, input logic [3:0] l);
		chk({xistor_on, led_on}, {x, l});
	endtask

	// one-cycle press after a fresh falling edge, so back-to-back presses
	// never rewrite a button in one time step
	// bit 4 serial reset, 3 digit select, 2 view, 1 increment, 0 reset
	task automatic tap(input logic [4:0] b);
		gap(1);
		{serial_alarm_reset, digit_sel_btn, view_btn, digit_inc_btn,
			reset_btn} = b;
		gap(1);
		{serial_alarm_reset, digit_sel_btn, view_btn, digit_inc_btn,
			reset_btn} = 5'h00;
	endtask

	task automatic t_reset();
		out(4'h0, 4'h0);
		rd(spal_pkg::SEL_SP_CFG, 20'h0);
		rd(4'hd, 20'h0);
	endtask

	task automatic t_hyst();
		wr(spal_pkg::SEL_AL_CFG, 20'h40);
		wr(spal_pkg::SEL_LEVEL1, 20'h64);
		wr(spal_pkg::SEL_LEVEL1 + 4'h1, 20'h3e8);
		wr(spal_pkg::SEL_SP_HYST, 20'ha);
		rdg(20'h68, 20'h0);
		out(4'h0, 4'h0);
		rdg(20'h6a, 20'h0);
		out(4'h1, 4'h1);
		rdg(20'h60, 20'h0);
		out(4'h1, 4'h1);
		gap(4);
		out(4'h1, 4'h1);
		rdg(20'h5e, 20'h0);
		out(4'h0, 4'h0);
	endtask

	task automatic t_pol();
		wr(spal_pkg::SEL_SP_CFG, 20'h38);
		rdg(20'h0, 20'h7d0);
		out(4'h2, 4'h0);
		rdg(20'h7d0, 20'h0);
		out(4'h1, 4'h3);
		wr(spal_pkg::SEL_SP_CFG, 20'hb8);
		rdg(20'h7d0, 20'h0);
		out(4'h1, 4'h0);
		wr(spal_pkg::SEL_SP_CFG, 20'h78);
		gap(3);
		out(4'h2, 4'h0);
		rdg(20'h7d0, 20'h0);
		out(4'h2, 4'h0);
	endtask

	task automatic t_alarm();
		wr(spal_pkg::SEL_SP_CFG, 20'h40);
		wr(spal_pkg::SEL_LEVEL1 + 4'h2, 20'h32);
		wr(spal_pkg::SEL_LEVEL1 + 4'h3, 20'h3e8);
		wr(spal_pkg::SEL_AL_HYST, 20'ha);
		wr(spal_pkg::SEL_DLY3, 20'h3);
		wr(spal_pkg::SEL_ALARM_FUNCTION_SELECT, 20'h4);
		wr(spal_pkg::SEL_AL_CFG, 20'h0);
		rdg(20'h3c, 20'h0);
		rdg(20'h3c, 20'h0);
		out(4'h0, 4'h0);
		rdg(20'h3c, 20'h0);
		out(4'h4, 4'h4);
		rdg(20'h1e, 20'h0);
		out(4'h4, 4'h4);
		ext_alarm_reset_n = 1'b0;
		gap(3);
		out(4'h4, 4'h4);
		ext_alarm_reset_n = 1'b1;
		tap(5'h01);
		gap(2);
		out(4'h0, 4'h0);
		wr(spal_pkg::SEL_DLY3, 20'h0);
		wr(spal_pkg::SEL_ALARM_FUNCTION_SELECT, 20'h0);
		rdg(20'h3c, 20'h0);
		out(4'h4, 4'h4);
		rdg(20'h2d, 20'h0);
		out(4'h4, 4'h4);
		rdg(20'h23, 20'h0);
		out(4'h0, 4'h0);
		wr(spal_pkg::SEL_ALARM_FUNCTION_SELECT, 20'h4);
		wr(spal_pkg::SEL_AL_CFG, 20'h80);
		rdg(20'h3c, 20'h0);
		out(4'h4, 4'h4);
		ext_alarm_reset_n = 1'b0;
		gap(3);
		ext_alarm_reset_n = 1'b1;
		out(4'h0, 4'h0);
		rdg(20'h3c, 20'h0);
		out(4'h4, 4'h4);
		tap(5'h10);
		gap(2);
		out(4'h0, 4'h0);
	endtask

	// partner-relative levels: setpoint one is 100, own amount 20
	task automatic t_dev();
		wr(spal_pkg::SEL_AL_CFG, 20'h0);
		wr(spal_pkg::SEL_ALARM_FUNCTION_SELECT, 20'h1);
		wr(spal_pkg::SEL_LEVEL1 + 4'h2, 20'h14);
		rdg(20'h73, 20'h0);
		out(4'h0, 4'h0);
		rdg(20'h7d, 20'h0);
		out(4'h4, 4'h4);
		wr(spal_pkg::SEL_ALARM_FUNCTION_SELECT, 20'h2);
		rdg(20'h41, 20'h0);
		out(4'h0, 4'h0);
		rdg(20'h55, 20'h0);
		out(4'h4, 4'h4);
	endtask

	// only setpoint three is active here
	task automatic t_flash();
		logic [2:0] s;
		for (int i = 0; i < 6; i++) begin
			s = 3'(i);
			wr(spal_pkg::SEL_OUT_CFG, {12'h0, s, 5'h0});
			rdg(20'h55, 20'h0);
			chk(display_flash, (s == 3'h3 || s == 3'h5));
		end
	endtask

	// band of +/- 20 around setpoint one at 100, alarm hysteresis 10
	task automatic t_band();
		wr(spal_pkg::SEL_ALARM_FUNCTION_SELECT, 20'h3);
		wr(spal_pkg::SEL_AL_CFG, 20'h2);
		rdg(20'h64, 20'h0);
		out(4'h4, 4'h0);
		rdg(20'h7d, 20'h0);
		out(4'h0, 4'h4);
		rdg(20'h73, 20'h0);
		out(4'h0, 4'h4);
		rdg(20'h64, 20'h0);
		out(4'h4, 4'h0);
		wr(spal_pkg::SEL_AL_CFG, 20'h5);
		rdg(20'h64, 20'h0);
		out(4'h0, 4'h0);
		rdg(20'h0, 20'h64);
		out(4'h4, 4'h4);
		rdg(20'h0, 20'h7d);
		out(4'h4, 4'h4);
		rdg(20'h0, 20'h87);
		out(4'h0, 4'h0);
	endtask

	task automatic t_view();
		tap(5'h04);
		gap(2);
		chk({view_active, view_index}, 3'h4);
		tap(5'h02);
		gap(1);
		tap(5'h04);
		rd(spal_pkg::SEL_LEVEL1, 20'h65);
		gap(36);
		chk({view_active, view_index}, 3'h5);
		gap(20);
		chk({view_active, view_index}, 3'h6);
		gap(120);
		chk(view_active, 1'b0);
		tap(5'h04);
		tap(5'h02);
		tap(5'h08);
		tap(5'h02);
		gap(1);
		chk({view_value, view_digit}, {20'h70, 3'h1});
		tap(5'h01);
		rd(spal_pkg::SEL_LEVEL1, 20'h65);
		chk(view_active, 1'b0);
	endtask

	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		cfg_wr = 1'b0;
		cfg_sel = 4'h0;
		cfg_wdata = 20'h0;
		rd_sel = 4'h0;
		view_btn = 1'b0;
		digit_inc_btn = 1'b0;
		reset_btn = 1'b0;
		digit_sel_btn = 1'b0;
		serial_alarm_reset = 1'b0;
		ext_alarm_reset_n = 1'b1;
		n_fail = 0;
		n_compared = 0;
		cyc = 0;
		repeat (20) @(negedge clk);
		reset_n = 1'b1;
		t_reset();
		t_hyst();
		t_pol();
		t_alarm();
		t_dev();
		t_flash();
		t_band();
		t_view();
		test_done();
	end
endmodule
